// ### logic/supply_status_pkg.sv
// package: opcodes, bit layout, reset values and state record of the status block
package supply_status_pkg;

	// command opcodes of the decoded remote command port
	typedef enum logic [4:0] {
		OP_NONE         = 5'h00,
		OP_OPER_COND_RD = 5'h01,
		OP_OPER_ENAB_WR = 5'h02,
		OP_OPER_ENAB_RD = 5'h03,
		OP_OPER_EVT_RD  = 5'h04,
		OP_QUES_COND_RD = 5'h05,
		OP_QUES_ENAB_WR = 5'h06,
		OP_QUES_ENAB_RD = 5'h07,
		OP_QUES_EVT_RD  = 5'h08,
		OP_STAT_PRESET  = 5'h09,
		OP_VOLT_WR      = 5'h0A,
		OP_VOLT_RD      = 5'h0B,
		OP_VOLT_LIM_WR  = 5'h0C,
		OP_VOLT_LIM_RD  = 5'h0D,
		OP_VOLT_TRIG_WR = 5'h0E,
		OP_VOLT_TRIG_RD = 5'h0F,
		OP_MODE_RD      = 5'h10,
		OP_TRIGGER      = 5'h11
	} cmd_op_e;

	// operation group bit positions
	localparam int unsigned OPER_CAL_BIT   = 0;
	localparam int unsigned OPER_WAIT_BIT  = 5;
	localparam int unsigned OPER_CV_BIT    = 8;
	localparam int unsigned OPER_CC_BIT    = 10;
	localparam logic [15:0] OPER_USED_MASK = 16'h0521;
	// questionable group bit positions
	localparam int unsigned QUES_OT_BIT    = 3;
	localparam logic [15:0] QUES_USED_MASK = 16'h0008;
	// status byte summary positions
	localparam int unsigned STB_OPER_BIT   = 7;
	localparam int unsigned STB_QUES_BIT   = 3;

	// reset and preset values
	localparam logic [15:0] OPER_MASK_RESET = 16'h0000;
	localparam logic [15:0] QUES_MASK_RESET = 16'h0000;
	localparam logic [15:0] VOLT_SET_RESET  = 16'h0000;
	localparam logic [15:0] VOLT_LIM_RESET  = 16'hFFFF;
	localparam logic [15:0] VOLT_TRIG_RESET = 16'h0000;

	// mode query answers and error codes (two's complement)
	localparam logic [15:0] MODE_VOLT_CODE  = 16'h0001;
	localparam logic [15:0] MODE_CURR_CODE  = 16'h0002;
	localparam logic [15:0] ERR_SETTING_LIM = 16'hFED3;
	localparam logic [15:0] ERR_DATA_RANGE  = 16'hFF22;

	// live condition inputs, one bit each
	typedef struct packed {
		logic const_current_flag;
		logic const_voltage_flag;
		logic trigger_wait_flag;
		logic cal_busy_flag;
		logic overheat_flag;
	} cond_s;

	// decoded command from the remote interface parser
	typedef struct packed {
		logic        valid;
		cmd_op_e     op;
		logic [15:0] data;
	} cmd_s;

	typedef struct packed {
		cond_s       sync1;
		cond_s       sync2;
		cond_s       sync3;
		cond_s       cond;
		logic [15:0] oper_mask;
		logic [15:0] ques_mask;
		logic [15:0] oper_evt;
		logic [15:0] ques_evt;
		logic [15:0] volt_set;
		logic [15:0] volt_lim;
		logic [15:0] volt_trig;
		logic        rsp_valid;
		logic [15:0] rsp_data;
		logic        err_post;
		logic [15:0] err_code;
	} state_s;

endpackage : supply_status_pkg

// ### logic/supply_status_reporting.sv
// status reporting block of a programmable dc source: operation and questionable groups
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// (R1) triggered query returns stored trigger voltage
// (R2) mode query: VOLT in cv, CURR in cc
// (R3) operation condition register is live, unlatched
// (R4) bit 10 constant current, bit 8 voltage
// (R5) bit 5 waiting for trigger
// (R6) bit 0 computing calibration constants
// (R7) values exchanged as integers 0 to 1313
// (R8) status bit 7 ORs enabled operation events
// (R9) event register accumulates conditions since read
// (R10) second event read without changes returns zero
// (R11) overheat event reads 8 once only
// (R12) questionable condition reads 8 while overheated
// (R13) preset returns both masks to preset
// (R14) cv plus trigger wait reads 288
// (R15) voltage above limit rejected, error posted
// (R16) reading operation events clears them
// (R17) questionable bit 3 overheat, others unused
// (R18) status bit 3 ORs enabled questionable events
// (R19) unused bits read zero, mask writes ignored
// (R20) event set on rise, held until read
module supply_status_reporting
	import supply_status_pkg::*;
(
	input  wire logic        CLK_SYS_I,
	input  wire logic        RST_N_I,
	input  wire cmd_s        CMD_I,
	input  wire cond_s       COND_I,
	output logic             RSP_VALID_O,
	output logic [15:0]      RSP_DATA_O,
	output logic             ERR_POST_O,
	output logic [15:0]      ERR_CODE_O,
	output logic [15:0]      VOLT_OUT_O,
	output logic             STB_OPER_SUM_O,
	output logic             STB_QUES_SUM_O
);

	state_s q;
	state_s n;

	// map live flags onto the operation group word
	function automatic logic [15:0] oper_word(input cond_s c);
		logic [15:0] w;
		w = 16'h0000;
		w[OPER_CC_BIT]   = c.const_current_flag; // R4
		w[OPER_CV_BIT]   = c.const_voltage_flag; // R4
		w[OPER_WAIT_BIT] = c.trigger_wait_flag;  // R5
		w[OPER_CAL_BIT]  = c.cal_busy_flag;      // R6
		return w;
	endfunction : oper_word

	function automatic logic [15:0] ques_word(input cond_s c);
		logic [15:0] w;
		w = 16'h0000;
		w[QUES_OT_BIT] = c.overheat_flag; // R17
		return w;
	endfunction : ques_word

	logic [15:0] oper_rise;
	logic [15:0] ques_rise;
	logic        cmd_oper_evt_rd;
	logic        cmd_ques_evt_rd;

	always_comb begin
		n = q;
		n.sync1 = COND_I;
		n.sync2 = q.sync1;
		n.sync3 = q.sync2;
		// a flag only moves once two late stages agree, filtering metastable glitches
		for (int i = 0; i < $bits(cond_s); i++) begin
			if (q.sync2[i] == q.sync3[i]) begin
				n.cond[i] = q.sync3[i];
			end
		end
		oper_rise = oper_word(n.cond) & ~oper_word(q.cond); // R20
		ques_rise = ques_word(n.cond) & ~ques_word(q.cond); // R20
		cmd_oper_evt_rd = CMD_I.valid && (CMD_I.op == OP_OPER_EVT_RD);
		cmd_ques_evt_rd = CMD_I.valid && (CMD_I.op == OP_QUES_EVT_RD);
		// read clears, but a rise in the same cycle survives the clear
		n.oper_evt = (cmd_oper_evt_rd ? 16'h0000 : q.oper_evt) | oper_rise; // R9 R16 R10
		n.ques_evt = (cmd_ques_evt_rd ? 16'h0000 : q.ques_evt) | ques_rise; // R11
		n.rsp_valid = 1'b0;
		n.rsp_data  = 16'h0000;
		n.err_post  = 1'b0;
		if (CMD_I.valid) begin
			n.rsp_valid = 1'b1;
			case (CMD_I.op)
				OP_OPER_COND_RD: begin
					n.rsp_data = oper_word(q.cond); // R3 R14 R7
				end
				OP_OPER_ENAB_WR: begin
					n.oper_mask = CMD_I.data & OPER_USED_MASK; // R19 R7
				end
				OP_OPER_ENAB_RD: begin
					n.rsp_data = q.oper_mask;
				end
				OP_OPER_EVT_RD: begin
					n.rsp_data = q.oper_evt; // R9
				end
				OP_QUES_COND_RD: begin
					n.rsp_data = ques_word(q.cond); // R12
				end
				OP_QUES_ENAB_WR: begin
					n.ques_mask = CMD_I.data & QUES_USED_MASK; // R17
				end
				OP_QUES_ENAB_RD: begin
					n.rsp_data = q.ques_mask;
				end
				OP_QUES_EVT_RD: begin
					n.rsp_data = q.ques_evt; // R11
				end
				OP_STAT_PRESET: begin
					n.oper_mask = OPER_MASK_RESET; // R13
					n.ques_mask = QUES_MASK_RESET; // R13
				end
				OP_VOLT_WR: begin
					if (CMD_I.data > q.volt_lim) begin
						n.err_post = 1'b1; // R15
						n.err_code = ERR_SETTING_LIM;
					end else begin
						n.volt_set = CMD_I.data;
					end
				end
				OP_VOLT_RD: begin
					n.rsp_data = q.volt_set;
				end
				OP_VOLT_LIM_WR: begin
					n.volt_lim = CMD_I.data;
				end
				OP_VOLT_LIM_RD: begin
					n.rsp_data = q.volt_lim;
				end
				OP_VOLT_TRIG_WR: begin
					// trigger levels above the limit would drive past it later
					if (CMD_I.data > q.volt_lim) begin
						n.err_post = 1'b1;
						n.err_code = ERR_DATA_RANGE;
					end else begin
						n.volt_trig = CMD_I.data;
					end
				end
				OP_VOLT_TRIG_RD: begin
					n.rsp_data = q.volt_trig; // R1
				end
				OP_MODE_RD: begin
					// cv answers first when both flags are seen during a transition
					if (q.cond.const_voltage_flag) begin
						n.rsp_data = MODE_VOLT_CODE; // R2
					end else if (q.cond.const_current_flag) begin
						n.rsp_data = MODE_CURR_CODE; // R2
					end else begin
						n.rsp_data = 16'h0000;
					end
				end
				OP_TRIGGER: begin
					n.volt_set = q.volt_trig;
				end
				default: begin
					n.rsp_valid = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			q           <= '0;
			q.oper_mask <= OPER_MASK_RESET;
			q.ques_mask <= QUES_MASK_RESET;
			q.volt_set  <= VOLT_SET_RESET;
			q.volt_lim  <= VOLT_LIM_RESET;
			q.volt_trig <= VOLT_TRIG_RESET;
		end else begin
			q <= n;
		end
	end

	assign RSP_VALID_O    = q.rsp_valid;
	assign RSP_DATA_O     = q.rsp_data;
	assign ERR_POST_O     = q.err_post;
	assign ERR_CODE_O     = q.err_code;
	assign VOLT_OUT_O     = q.volt_set;
	assign STB_OPER_SUM_O = |(q.oper_evt & q.oper_mask); // R8
	assign STB_QUES_SUM_O = |(q.ques_evt & q.ques_mask); // R18

	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_N_I);

	property p_oper_evt_clear;
		(cmd_oper_evt_rd && oper_rise == 16'h0000) |=> (q.oper_evt == 16'h0000);
	endproperty
	a_oper_evt_clear: assert property (p_oper_evt_clear) // R16
		else $error("operation event not cleared by read");

	// the host leaves one idle cycle between commands, so the second read lands two on
	property p_second_read_zero;
		(cmd_oper_evt_rd && oper_rise == 16'h0000) ##1 (oper_rise == 16'h0000) ##1
			(cmd_oper_evt_rd && oper_rise == 16'h0000) |=> (RSP_DATA_O == 16'h0000);
	endproperty
	a_second_read_zero: assert property (p_second_read_zero) // R10
		else $error("second event read not zero");

	property p_cc_rise_latched;
		$rose(q.cond.const_current_flag) |-> q.oper_evt[OPER_CC_BIT];
	endproperty
	a_cc_rise_latched: assert property (p_cc_rise_latched) // R20
		else $error("cc rise not latched into event register");

	property p_ot_rise_latched;
		$rose(q.cond.overheat_flag) |-> q.ques_evt[QUES_OT_BIT];
	endproperty
	a_ot_rise_latched: assert property (p_ot_rise_latched) // R20
		else $error("overheat rise not latched into event register");

	property p_cond_live;
		(CMD_I.valid && CMD_I.op == OP_OPER_COND_RD)
			|=> (RSP_VALID_O && RSP_DATA_O == oper_word($past(q.cond)));
	endproperty
	a_cond_live: assert property (p_cond_live) // R3
		else $error("condition read does not match live flags");

	property p_ot_once;
		(cmd_ques_evt_rd && q.cond.overheat_flag && ques_rise == 16'h0000)
			##1 (ques_rise == 16'h0000) ##1 cmd_ques_evt_rd
			|=> (RSP_DATA_O == 16'h0000);
	endproperty
	a_ot_once: assert property (p_ot_once) // R11
		else $error("persisting overheat reported twice");

	property p_ot_cond;
		(CMD_I.valid && CMD_I.op == OP_QUES_COND_RD && q.cond.overheat_flag)
			|=> (RSP_DATA_O == 16'h0008);
	endproperty
	a_ot_cond: assert property (p_ot_cond) // R12
		else $error("questionable condition not 8 while overheated");

	property p_mask_write;
		(CMD_I.valid && CMD_I.op == OP_OPER_ENAB_WR)
			|=> (q.oper_mask == ($past(CMD_I.data) & 16'h0521));
	endproperty
	a_mask_write: assert property (p_mask_write) // R19
		else $error("operation mask not stored with unused bits dropped");

	property p_ques_mask_write;
		(CMD_I.valid && CMD_I.op == OP_QUES_ENAB_WR)
			|=> (q.ques_mask == ($past(CMD_I.data) & QUES_USED_MASK));
	endproperty
	a_ques_mask_write: assert property (p_ques_mask_write) // R17
		else $error("questionable mask not stored with unused bits dropped");

	property p_preset;
		(CMD_I.valid && CMD_I.op == OP_STAT_PRESET)
			|=> (q.oper_mask == 16'h0000 && q.ques_mask == 16'h0000);
	endproperty
	a_preset: assert property (p_preset) // R13
		else $error("preset did not clear both masks");

	property p_volt_reject;
		(CMD_I.valid && CMD_I.op == OP_VOLT_WR && CMD_I.data > q.volt_lim)
			|=> (ERR_POST_O && ERR_CODE_O == 16'hFED3 && $stable(q.volt_set));
	endproperty
	a_volt_reject: assert property (p_volt_reject) // R15
		else $error("over-limit voltage accepted or no error posted");

	property p_volt_accept;
		(CMD_I.valid && CMD_I.op == OP_VOLT_WR && CMD_I.data <= q.volt_lim)
			|=> (VOLT_OUT_O == $past(CMD_I.data) && !ERR_POST_O);
	endproperty
	a_volt_accept: assert property (p_volt_accept) // R15
		else $error("in-limit voltage not applied or error posted");

	property p_trig_reject;
		(CMD_I.valid && CMD_I.op == OP_VOLT_TRIG_WR && CMD_I.data > q.volt_lim)
			|=> (ERR_POST_O && ERR_CODE_O == ERR_DATA_RANGE && $stable(q.volt_trig));
	endproperty
	a_trig_reject: assert property (p_trig_reject) // R1
		else $error("over-limit trigger level accepted or no error posted");

	property p_trigger_apply;
		(CMD_I.valid && CMD_I.op == OP_TRIGGER)
			|=> (VOLT_OUT_O == $past(q.volt_trig));
	endproperty
	a_trigger_apply: assert property (p_trigger_apply) // R1
		else $error("trigger did not apply the stored level");

	property p_trig_query;
		(CMD_I.valid && CMD_I.op == OP_VOLT_TRIG_RD)
			|=> (RSP_DATA_O == $past(q.volt_trig));
	endproperty
	a_trig_query: assert property (p_trig_query) // R1
		else $error("triggered query returned wrong level");

	property p_mode_volt;
		(CMD_I.valid && CMD_I.op == OP_MODE_RD && q.cond.const_voltage_flag)
			|=> (RSP_DATA_O == 16'h0001);
	endproperty
	a_mode_volt: assert property (p_mode_volt) // R2
		else $error("mode query wrong in cv");

	property p_mode_curr;
		(CMD_I.valid && CMD_I.op == OP_MODE_RD && !q.cond.const_voltage_flag
			&& q.cond.const_current_flag) |=> (RSP_DATA_O == MODE_CURR_CODE);
	endproperty
	a_mode_curr: assert property (p_mode_curr) // R2
		else $error("mode query wrong in cc");

	property p_oper_sum;
		(q.oper_evt[OPER_CC_BIT] && q.oper_mask[OPER_CC_BIT]) |-> STB_OPER_SUM_O;
	endproperty
	a_oper_sum: assert property (p_oper_sum) // R8
		else $error("operation summary bit low with enabled event");

	property p_ques_sum;
		(q.ques_evt[QUES_OT_BIT] && q.ques_mask[QUES_OT_BIT]) |-> STB_QUES_SUM_O;
	endproperty
	a_ques_sum: assert property (p_ques_sum) // R18
		else $error("questionable summary bit low with enabled event");

	property p_cov_1312;
		cmd_oper_evt_rd && q.oper_evt == 16'h0520;
	endproperty
	c_cov_1312: cover property (p_cov_1312);

	property p_cov_288;
		q.cond.const_voltage_flag && q.cond.trigger_wait_flag && !q.cond.const_current_flag;
	endproperty
	c_cov_288: cover property (p_cov_288);

	property p_cov_reject;
		ERR_POST_O;
	endproperty
	c_cov_reject: cover property (p_cov_reject);

	property p_cov_ot_sum;
		STB_QUES_SUM_O ##1 cmd_ques_evt_rd;
	endproperty
	c_cov_ot_sum: cover property (p_cov_ot_sum);

endmodule : supply_status_reporting

`default_nettype wire

// ### dv/host_cmd_model.sv
// host side model: issues decoded commands and collects answers
`timescale 1ns/1ps
`default_nettype none

module host_cmd_model
	import supply_status_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rsp_valid_i,
	input  wire logic [15:0] rsp_data_i,
	input  wire logic        err_post_i,
	output var  cmd_s        cmd_o
);
	initial begin
		cmd_o = '{valid: 1'b0, op: OP_NONE, data: 16'h0000};
	end

	// one command, answer taken 1 ns after the same edge that takes the command
	task automatic send(input cmd_op_e op, input logic [15:0] d, output logic [15:0] rd,
		output logic rv, output logic ep);
		@(posedge clk_i);
		#1;
		cmd_o = '{valid: 1'b1, op: op, data: d};
		@(posedge clk_i);
		#1;
		rd = rsp_data_i;
		rv = rsp_valid_i;
		ep = err_post_i;
		// released data is not left showing the last word
		cmd_o = '{valid: 1'b0, op: OP_NONE, data: ~d};
	endtask : send
endmodule : host_cmd_model

`default_nettype wire

// ### dv/supply_status_reporting_tb_top.sv
// self-checking bench of the status reporting block
`timescale 1ns/1ps
`default_nettype none

module supply_status_reporting_tb_top
	import supply_status_pkg::*;
;
	logic        clk;
	logic        rst_n;
	cmd_s        cmd;
	cond_s       cond;
	logic        rsp_valid;
	logic [15:0] rsp_data;
	logic        err_post;
	logic [15:0] err_code;
	logic [15:0] volt_out;
	logic        sum_oper;
	logic        sum_ques;
	logic [15:0] rd;
	logic        rv;
	logic        ep;
	int          errors;
	int          compares;

	supply_status_reporting dut_u (
		.CLK_SYS_I     (clk),
		.RST_N_I       (rst_n),
		.CMD_I         (cmd),
		.COND_I        (cond),
		.RSP_VALID_O   (rsp_valid),
		.RSP_DATA_O    (rsp_data),
		.ERR_POST_O    (err_post),
		.ERR_CODE_O    (err_code),
		.VOLT_OUT_O    (volt_out),
		.STB_OPER_SUM_O(sum_oper),
		.STB_QUES_SUM_O(sum_ques)
	);

	host_cmd_model host_u (
		.clk_i      (clk),
		.rsp_valid_i(rsp_valid),
		.rsp_data_i (rsp_data),
		.err_post_i (err_post),
		.cmd_o      (cmd)
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic final_report();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report

	task automatic q(input cmd_op_e op, input logic [15:0] d);
		host_u.send(op, d, rd, rv, ep);
		check("rsp_valid", {15'h0000, rv}, 16'h0001);
	endtask : q

	// cc, cv, wait, cal, overheat; lets the input synchroniser settle
	task automatic set_cond(input logic [4:0] c);
		@(posedge clk);
		#1;
		cond = c;
		repeat (6) @(posedge clk);
		#1;
	endtask : set_cond

	initial begin
		errors = 0;
		compares = 0;
		cond = '0;
		rst_n = 1'b0;
		repeat (16) @(posedge clk);
		#1;
		rst_n = 1'b1;
		check("volt_out", volt_out, 16'h0000);
		set_cond(5'b01100);
		q(OP_OPER_COND_RD, 16'h0000); check("cond", rd, 16'h0120);
		q(OP_MODE_RD, 16'h0000); check("mode", rd, MODE_VOLT_CODE);
		set_cond(5'b11100);
		q(OP_OPER_COND_RD, 16'h0000); check("cond", rd, 16'h0520);
		q(OP_OPER_EVT_RD, 16'h0000); check("evt", rd, 16'h0520);
		q(OP_OPER_EVT_RD, 16'h0000); check("evt", rd, 16'h0000);
		set_cond(5'b10100);
		q(OP_MODE_RD, 16'h0000); check("mode", rd, MODE_CURR_CODE);
		q(OP_OPER_EVT_RD, 16'h0000); check("evt", rd, 16'h0000);
		set_cond(5'b11110);
		q(OP_OPER_COND_RD, 16'h0000); check("cond", rd, 16'h0521);
		q(OP_OPER_ENAB_WR, 16'hFFFF);
		q(OP_OPER_ENAB_RD, 16'h0000); check("omask", rd, 16'h0521);
		check("sum_oper", {15'h0000, sum_oper}, 16'h0001);
		q(OP_OPER_EVT_RD, 16'h0000); check("evt", rd, 16'h0101);
		check("sum_oper", {15'h0000, sum_oper}, 16'h0000);
		set_cond(5'b00000);
		q(OP_OPER_COND_RD, 16'h0000); check("cond", rd, 16'h0000);
		q(OP_MODE_RD, 16'h0000);
		check("mode", rd, 16'h0000);
		set_cond(5'b00001);
		q(OP_QUES_ENAB_WR, 16'hFFFF);
		q(OP_QUES_ENAB_RD, 16'h0000); check("qmask", rd, 16'h0008);
		check("sum_ques", {15'h0000, sum_ques}, 16'h0001);
		q(OP_QUES_EVT_RD, 16'h0000); check("qevt", rd, 16'h0008);
		q(OP_QUES_EVT_RD, 16'h0000); check("qevt", rd, 16'h0000);
		q(OP_QUES_COND_RD, 16'h0000); check("qcond", rd, 16'h0008);
		check("sum_ques", {15'h0000, sum_ques}, 16'h0000);
		q(OP_STAT_PRESET, 16'h0000);
		q(OP_OPER_ENAB_RD, 16'h0000); check("omask", rd, OPER_MASK_RESET);
		q(OP_QUES_ENAB_RD, 16'h0000); check("qmask", rd, QUES_MASK_RESET);
		q(OP_VOLT_LIM_WR, 16'h012C);
		q(OP_VOLT_LIM_RD, 16'h0000);
		check("vlim", rd, 16'h012C);
		q(OP_VOLT_WR, 16'h00DD); check("volt_out", volt_out, 16'h00DD);
		check("err_post", {15'h0000, ep}, 16'h0000);
		q(OP_VOLT_WR, 16'h014D); check("err_post", {15'h0000, ep}, 16'h0001);
		check("err_code", err_code, ERR_SETTING_LIM);
		q(OP_VOLT_RD, 16'h0000); check("volt", rd, 16'h00DD);
		q(OP_VOLT_TRIG_WR, 16'h0100);
		q(OP_VOLT_TRIG_RD, 16'h0000); check("trig", rd, 16'h0100);
		// a trigger level above the limit is refused and the old level kept
		q(OP_VOLT_TRIG_WR, 16'h014D);
		check("err_post", {15'h0000, ep}, 16'h0001);
		check("err_code", err_code, ERR_DATA_RANGE);
		q(OP_VOLT_TRIG_RD, 16'h0000);
		check("trig", rd, 16'h0100);
		q(OP_VOLT_RD, 16'h0000); check("volt", rd, 16'h00DD);
		q(OP_TRIGGER, 16'h0000); check("volt_out", volt_out, 16'h0100);
		// mid-run reset brings back the power-up limit and output level
		@(posedge clk);
		#1;
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		rst_n = 1'b1;
		check("volt_out", volt_out, VOLT_SET_RESET);
		q(OP_VOLT_LIM_RD, 16'h0000);
		check("vlim", rd, VOLT_LIM_RESET);
		q(OP_OPER_ENAB_RD, 16'h0000);
		check("omask", rd, OPER_MASK_RESET);
		final_report();
	end

	// whole sequence needs about 130 cycles
	initial begin
		#200000;
		errors++;
		final_report();
	end
endmodule : supply_status_reporting_tb_top

`default_nettype wire
